// >>> hdl/sosc_op_state.sv
// sosc_op_state: operational-state register and bank generation register
// assumes a serial front end that presents whole byte accesses as strobes
`timescale 1ns/10ps

// Behaviour
// - start bit starts measurement only when measuring
// - power-down bit, one after reset
// - reserved bits read zero, host writes zero
// - soft reset bit always reads zero
// - 010 configure, 011 measure, others keep
// - state field reads 010 or 011
// - configuration opens control bank, no measurement
// - results only in measurement, control bank closed
// - back to configuration stops, clears, keeps
// - no-change pattern still applies power-down bit, start bit only when measuring
// - soft reset stops, configures, resets registers
// - start bit clears on reset and configuration
// - state field 010 after reset or return
// - power down only between conversions when measuring
// - start with power-down overrides power down
// - state and start in one write
// - generation register read-only, id and revision in configuration, reads zero when measuring
// - done low at conversion start, high end
// - upper four address bits ignored
module sosc_op_state #(
   parameter logic [3:0] DEVICE_ID   = sosc_pkg::DEF_DEVICE_ID,
   parameter logic [3:0] BANK_REV    = sosc_pkg::DEF_BANK_REV,
   parameter int         CONV_CYCLES = sosc_pkg::CONV_CYCLES
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire sosc_pkg::sosc_req_t  req,
   output logic [7:0]                rdData,
   output logic                      rdHit,
   output sosc_pkg::sosc_stat_t      stat,
   output logic                      convDone
);
   import sosc_pkg::*;

   typedef struct packed {
      sosc_state_t state;
      logic        startBit;
      logic        pwrDn;
      logic        softRstPulse;
      logic        clearPulse;
      logic [7:0]  rdData;
      logic        rdHit;
   } sosc_bank_t;

   sosc_bank_t st_reg;
   sosc_bank_t st_next;

   logic       convBusy;
   logic       convStart;
   logic       wrOp;
   logic       rdOp;
   logic [2:0] wrState;

   // decode an address nibble against an offset; high nibble never looked at
   function automatic logic hitOffset(input logic [7:0] a, input logic [3:0] off);
      return a[3:0] == off;
   endfunction : hitOffset

   // state field image shown on reads
   function automatic logic [2:0] stateCode(input sosc_state_t s);
      return (s == SOSC_MEASURE) ? STATE_MEASURE : STATE_CONFIG;
   endfunction : stateCode

   assign wrOp    = req.wrStrobe && hitOffset(req.addr, OFF_OP_STATE);
   assign rdOp    = req.rdStrobe;
   assign wrState = req.wrData[POS_STATE_HI -: 3];

   // next-state logic of the register bank
   always_comb begin
      st_next              = st_reg;
      st_next.softRstPulse = 1'b0;
      st_next.clearPulse   = 1'b0;
      st_next.rdHit        = 1'b0;
      if (wrOp && req.wrData[POS_SOFTRST]) begin
         // soft reset: everything back to reset values, bit not stored
         st_next.state        = SOSC_CONFIG;
         st_next.startBit     = RST_START;
         st_next.pwrDn        = RST_PWRDN;
         st_next.softRstPulse = 1'b1;
         st_next.clearPulse   = st_reg.state == SOSC_MEASURE;
      end else if (wrOp) begin
         // power-down bit takes effect whatever the state code says; start bit is cleared by 010, or by a no-change code while in configuration
         st_next.pwrDn    = req.wrData[POS_PWRDN];
         st_next.startBit = req.wrData[POS_START];
         unique case (wrState)
            STATE_CONFIG: begin
               st_next.state    = SOSC_CONFIG;
               st_next.startBit = 1'b0;
               if (st_reg.state == SOSC_MEASURE) begin
                  st_next.clearPulse = 1'b1;
               end
            end
            STATE_MEASURE: begin
               st_next.state = SOSC_MEASURE;
            end
            default: begin
               // no-change patterns keep state
               if (st_reg.state == SOSC_CONFIG) begin
                  st_next.startBit = 1'b0;
               end
            end
         endcase
      end
      // read path: state code always 010/011, bit 3 and bits 5:4 read zero
      if (rdOp) begin
         st_next.rdHit  = 1'b1;
         st_next.rdData = 8'h00;
         if (hitOffset(req.addr, OFF_OP_STATE)) begin
            st_next.rdData[POS_START]          = st_reg.startBit;
            st_next.rdData[POS_PWRDN]          = st_reg.pwrDn;
            st_next.rdData[5:4]                = RST_RESERVED;
            st_next.rdData[POS_SOFTRST]        = 1'b0;
            st_next.rdData[POS_STATE_HI -: 3]  = stateCode(st_reg.state);
         end else if (hitOffset(req.addr, OFF_BANK_GEN) && st_reg.state == SOSC_CONFIG) begin
            st_next.rdData = {DEVICE_ID, BANK_REV};
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_reg <= '{state: SOSC_CONFIG, startBit: RST_START, pwrDn: RST_PWRDN,
                     softRstPulse: 1'b0, clearPulse: 1'b0, rdData: 8'h00, rdHit: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // start pulse issued from the stored bit, only in measurement state
   assign convStart = st_reg.startBit && st_reg.state == SOSC_MEASURE && !convBusy;

   sosc_conv_timer #(
      .CYCLES   (CONV_CYCLES)
   ) u_timer (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .start    (convStart && !st_reg.softRstPulse),
      .abort    (st_reg.softRstPulse || st_reg.clearPulse ||
                 st_reg.state == SOSC_CONFIG),
      .busy     (convBusy),
      .convDone (convDone)
   );

   // status: control bank open only in configuration, results only in measurement
   always_comb begin
      stat.measureState    = st_reg.state == SOSC_MEASURE;
      stat.converting      = convBusy;
      stat.controlBankOpen = st_reg.state == SOSC_CONFIG;
      stat.resultBankOpen  = st_reg.state == SOSC_MEASURE;
      stat.clearResults    = st_reg.clearPulse || st_reg.softRstPulse;
      // while measuring, power down waits for a break; a pending start overrides it
      if (st_reg.state == SOSC_MEASURE) begin
         stat.powerDown = st_reg.pwrDn && !convBusy && !convStart;
      end else begin
         stat.powerDown = st_reg.pwrDn;
      end
   end

   assign rdData = st_reg.rdData;
   assign rdHit  = st_reg.rdHit;

endmodule : sosc_op_state

// >>> inc/sosc_pkg.sv
// sosc_pkg: constants and carrier types for the operational-state register bank
// assumes an 8-bit register port with a 4-bit-ignored address nibble in front
package sosc_pkg;

   // register offsets (low nibble of the address only)
   localparam logic [3:0] OFF_OP_STATE  = 4'h0;
   localparam logic [3:0] OFF_BANK_GEN  = 4'h2;

   // operational-state register field positions
   localparam int         POS_START     = 7;
   localparam int         POS_PWRDN     = 6;
   localparam int         POS_SOFTRST   = 3;
   localparam int         POS_STATE_HI  = 2;

   // state field codes
   localparam logic [2:0] STATE_CONFIG  = 3'h2;
   localparam logic [2:0] STATE_MEASURE = 3'h3;

   // reset values
   localparam logic       RST_START     = 1'b0;
   localparam logic       RST_PWRDN     = 1'b1;
   localparam logic [1:0] RST_RESERVED  = 2'h0;

   // identity nibbles: arbitrary neutral values
   localparam logic [3:0] DEF_DEVICE_ID = 4'h5;
   localparam logic [3:0] DEF_BANK_REV  = 4'h3;

   // timing: default conversion length in ns, and in 4 ns cycles
   localparam int         CLK_PERIOD_NS = 4;
   localparam int         CONV_TIME_NS  = 1000;
   localparam int         CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic {SOSC_CONFIG, SOSC_MEASURE} sosc_state_t;

   // register access from the serial front end
   typedef struct packed {
      logic       wrStrobe;
      logic       rdStrobe;
      logic [7:0] addr;
      logic [7:0] wrData;
   } sosc_req_t;

   // status shown to the rest of the chip
   typedef struct packed {
      logic       measureState;
      logic       converting;
      logic       powerDown;
      logic       controlBankOpen;
      logic       resultBankOpen;
      logic       clearResults;
   } sosc_stat_t;

endpackage : sosc_pkg

// >>> hdl/sosc_conv_timer.sv
// sosc_conv_timer: conversion sequencer, runs one conversion of fixed length
// assumes start/abort are levels from the register bank; abort stays high throughout configuration
`timescale 1ns/10ps
module sosc_conv_timer #(
   parameter int CYCLES = sosc_pkg::CONV_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic start,
   input  wire logic abort,
   output logic      busy,
   output logic      convDone
);
   import sosc_pkg::*;

   typedef struct packed {
      logic        busy;
      logic        done;
      logic [31:0] count;
   } sosc_tmr_t;

   sosc_tmr_t st_reg;
   sosc_tmr_t st_next;

   // abort beats start so a state change always halts the converter
   always_comb begin
      st_next = st_reg;
      if (abort) begin
         // a cut conversion leaves done high, so done never sticks low without busy
         st_next.busy  = 1'b0;
         st_next.done  = 1'b1;
         st_next.count = 32'h0000_0000;
      end else if (start && !st_reg.busy) begin
         st_next.busy  = 1'b1;
         st_next.done  = 1'b0;
         st_next.count = 32'h0000_0000;
      end else if (st_reg.busy) begin
         if (st_reg.count >= 32'(CYCLES - 1)) begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
         end else begin
            st_next.count = st_reg.count + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_reg <= '{busy: 1'b0, done: 1'b1, count: 32'h0000_0000};
      end else begin
         st_reg <= st_next;
      end
   end

   assign busy     = st_reg.busy;
   assign convDone = st_reg.done;

endmodule : sosc_conv_timer

// >>> testbench/sosc_op_state_monitor.sv
// sosc_op_state_monitor: port assertions for the operational-state bank
// assumes it is bound onto sosc_op_state and sees only its ports
`timescale 1ns/10ps
module sosc_op_state_monitor #(
   parameter int CONV_CYCLES = 4
) (
   input wire logic                 sys_clk,
   input wire logic                 rst,
   input wire sosc_pkg::sosc_req_t  req,
   input wire logic [7:0]           rdData,
   input wire logic                 rdHit,
   input wire sosc_pkg::sosc_stat_t stat,
   input wire logic                 convDone
);
   import sosc_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // state register write; the upper address nibble must not matter
   logic wrOp;
   assign wrOp = req.wrStrobe && req.addr[3:0] == OFF_OP_STATE;
   // only the state register has these bits forced; the generation register is free there
   property p_zero_bits; rdHit && $past(req.addr[3:0]) == OFF_OP_STATE |-> rdData[5:3] == 3'h0; endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("reserved or reset bit read set");
   property p_dos_read; rdHit && $past(req.addr[3:0]) == OFF_OP_STATE
      |-> rdData[2:0] == ($past(stat.measureState) ? STATE_MEASURE : STATE_CONFIG); endproperty
   a_dos_read: assert property (p_dos_read) else $error("state field read wrong");
   property p_to_cfg; wrOp && req.wrData[3:0] == 4'h2 |=> !stat.measureState; endproperty
   a_to_cfg: assert property (p_to_cfg) else $error("config code ignored");
   property p_to_meas; wrOp && req.wrData[3:0] == 4'h3 |=> stat.measureState; endproperty
   a_to_meas: assert property (p_to_meas) else $error("measure code ignored");
   property p_nop; wrOp && !req.wrData[3] && req.wrData[2:1] != 2'b01 |=> $stable(stat.measureState); endproperty
   a_nop: assert property (p_nop) else $error("no-change code moved state");
   property p_swres; wrOp && req.wrData[3] |=> !stat.measureState && stat.powerDown; endproperty
   a_swres: assert property (p_swres) else $error("soft reset incomplete");
   property p_clear; $fell(stat.measureState) |-> ##[0:1] stat.clearResults; endproperty
   a_clear: assert property (p_clear) else $error("results not cleared");
   property p_banks; stat.resultBankOpen == stat.measureState && stat.controlBankOpen != stat.measureState; endproperty
   a_banks: assert property (p_banks) else $error("bank gating wrong");
   // one cycle of grace: an abort lands the cycle after the state change
   property p_cfg_idle; stat.controlBankOpen && $past(stat.controlBankOpen) |-> !stat.converting; endproperty
   a_cfg_idle: assert property (p_cfg_idle) else $error("conversion in config");
   property p_done; convDone == !stat.converting; endproperty
   a_done: assert property (p_done) else $error("done level wrong");
   // cycles the converter has been busy so far; a conversion never outlasts its length
   int convLen;
   always_ff @(posedge sys_clk) begin
      convLen <= (rst || !stat.converting) ? 0 : convLen + 1;
   end
   property p_conv_len; stat.converting |-> convLen < CONV_CYCLES; endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion too long");
   c_start: cover property (wrOp && req.wrData == 8'h83);
   c_conv: cover property ($rose(stat.converting));
   c_back: cover property ($fell(stat.measureState));
endmodule : sosc_op_state_monitor
bind sosc_op_state sosc_op_state_monitor #(.CONV_CYCLES(CONV_CYCLES)) u_mon (.sys_clk(sys_clk), .rst(rst),
   .req(req), .rdData(rdData), .rdHit(rdHit), .stat(stat), .convDone(convDone));

// >>> testbench/sosc_host_model.sv
// sosc_host_model: register-port host issuing single-byte accesses
// assumes the bench calls wr and rd one at a time
`timescale 1ns/10ps
module sosc_host_model (
   input wire logic           sys_clk,
   input wire logic           rdHit,
   input wire logic [7:0]     rdData,
   output sosc_pkg::sosc_req_t req
);
   import sosc_pkg::*;
   initial req = '0;
   // strobe for one cycle, then scramble address and data so stale values never help
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      req <= '{1'b1, 1'b0, a, d & 8'hCF};
      @(negedge sys_clk);
      req <= '{1'b0, 1'b0, ~a, ~d};
   endtask : wr
   // answer is due exactly one cycle after the read edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      req <= '{1'b0, 1'b1, a, 8'hA5};
      @(negedge sys_clk);
      req <= '{1'b0, 1'b0, ~a, 8'h5A};
      d = (rdHit === 1'b1) ? rdData : 8'hxx;
   endtask : rd
endmodule : sosc_host_model

// >>> testbench/tb.sv
// tb: register access sequence against sosc_op_state with expected values
// assumes the host model drives the port and the monitor is bound to dut
`timescale 1ns/10ps
module tb;
   import sosc_pkg::*;
   logic       sys_clk;
   logic       rst;
   sosc_req_t  hostReq;
   sosc_stat_t stat;
   logic [7:0] rdData;
   logic [7:0] rdVal;
   logic       rdHit;
   logic       convDone;
   int         err_total = 0;
   int         checks_done = 0;
   // steps: write address, write data, read address, expected read
   logic [7:0] stepTab [10][4] = '{
      '{8'hF0, 8'h80, 8'h00, 8'h02},
      '{8'h02, 8'hFF, 8'h02, {DEF_DEVICE_ID, DEF_BANK_REV}},
      '{8'h00, 8'h01, 8'h00, 8'h02},
      '{8'h00, 8'h83, 8'h00, 8'h83},
      '{8'h00, 8'h84, 8'h00, 8'h83},
      '{8'h00, 8'hC0, 8'h00, 8'hC3},
      '{8'h00, 8'h00, 8'h02, 8'h00},
      '{8'h00, 8'h82, 8'h00, 8'h02},
      '{8'h00, 8'hC3, 8'h00, 8'hC3},
      '{8'h00, 8'h0A, 8'h00, 8'h42}};
   // short conversions keep the run brief
   sosc_op_state #(.CONV_CYCLES(4)) dut (.sys_clk(sys_clk), .rst(rst), .req(hostReq), .rdData(rdData),
      .rdHit(rdHit), .stat(stat), .convDone(convDone));
   sosc_host_model host (.sys_clk(sys_clk), .rdHit(rdHit), .rdData(rdData), .req(hostReq));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
      checks_done++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, seen);
         err_total++;
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   // watchdog: the sequence needs under a hundred cycles
   initial begin
      repeat (3000) @(posedge sys_clk);
      err_total++;
      report_and_stop();
   end
   // main sequence
   initial begin
      rst = 1'b1;
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      chk("convDone", 8'h01, {7'h00, convDone});
      host.rd(8'h00, rdVal);
      chk("reset value", 8'h42, rdVal);
      chk("powerDown", 8'h01, {7'h00, stat.powerDown});
      for (int i = 0; i < 10; i++) begin
         host.wr(stepTab[i][0], stepTab[i][1]);
         if (i == 3) begin
            for (int k = 0; k < 8 && convDone !== 1'b0; k++) @(negedge sys_clk);
            chk("convDone", 8'h00, {7'h00, convDone});
         end
         host.rd(stepTab[i][2], rdVal);
         chk("register", stepTab[i][3], rdVal);
         if (i == 0) chk("powerDown", 8'h00, {7'h00, stat.powerDown});
         if (i == 0) chk("converting", 8'h00, {7'h00, stat.converting});
         if (i == 5) chk("powerDown", 8'h00, {7'h00, stat.powerDown});
         if (i == 7) chk("converting", 8'h00, {7'h00, stat.converting});
      end
      report_and_stop();
   end
endmodule : tb
